// ===== include/step_params.svh
// Purpose: timing counts, register offsets, field positions, reset values
// Assumes: 20 MHz core clock
// Notes: byte offsets within a 32-byte page; page 0..2 channel, page 3 global
`ifndef STEP_PARAMS_SVH
`define STEP_PARAMS_SVH

// ****************************************
// timing
// ****************************************
`define CLK_HZ 25'h131_2d00
`define CLK_MHZ 20
`define PULSE_NS 5000
`define PULSE_CYC ((`PULSE_NS * `CLK_MHZ + 999) / 1000)
`define MAX_PPS 14'h2710
`define MIN_PPS 14'h0001

// ****************************************
// register map
// ****************************************
`define NUM_CH 3
`define PAGE_GLOBAL 2'h3
`define OFS_SPEED 5'h00
`define OFS_RAMP 5'h04
`define OFS_ARG 5'h08
`define OFS_CMD 5'h0c
`define OFS_POS 5'h10
`define OFS_RELCNT 5'h14
`define OFS_IRQ_STAT 5'h00
`define OFS_IRQ_MASK 5'h04
`define OFS_CTRL 5'h08

// ****************************************
// fields and reset values
// ****************************************
`define CMD_REL 0
`define CMD_ABS 1
`define CMD_ABORT 2
`define CMD_HOME 3
`define CTRL_SOFT_RST 0
`define CTRL_HALF_LSB 1
`define SPEED_RST 14'h0000
`define RAMP_RST 16'h0001
`define MASK_RST 3'h0

`endif

// ===== include/step_pkg.sv
// Purpose: shared types of the stepper controller
// Assumes: nothing
// Notes: constants live in step_params.svh
package step_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DIV = 3'b010,
        ST_RUN = 3'b100
    } move_state_t;

    typedef logic [13:0] rate_t;
    typedef logic [15:0] ramp_t;

endpackage

// ===== include/rate_if.sv
// Purpose: carrier between a channel sequencer and its step rate generator
// Assumes: single clock domain
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
interface rate_if;
    logic run;
    step_pkg::rate_t rate;
    logic tick;

    modport src (output run, output rate, input tick);
    modport gen (input run, input rate, output tick);
endinterface

// ===== rtl/step_rate_gen.sv
// Purpose: phase accumulator that issues step ticks at rate pulses/second
// Assumes: rate never above the clock frequency
// Notes: first tick comes a full period after run rises
`timescale 1ns/1ps
`include "step_params.svh"
module step_rate_gen (
    input wire logic core_clk,
    input wire logic reset,
    rate_if.gen rif
);
    logic [24:0] acc_q;
    logic [25:0] sum;

    assign sum = {1'b0, acc_q} + {12'h000, rif.rate};

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            acc_q <= 25'h000_0000;
            rif.tick <= 1'b0;
        end else if (!rif.run) begin
            acc_q <= 25'h000_0000;
            rif.tick <= 1'b0;
        end else if (sum >= {1'b0, `CLK_HZ}) begin
            acc_q <= 25'(sum - {1'b0, `CLK_HZ});
            rif.tick <= 1'b1;
        end else begin
            acc_q <= sum[24:0];
            rif.tick <= 1'b0;
        end
    end
endmodule

// ===== rtl/ramp_divider.sv
// Purpose: restoring divider giving the per-level rate increment
// Assumes: divisor non-zero
// Notes: quo and rem valid in the cycle busy falls; 14 cycles per division
`timescale 1ns/1ps
module ramp_divider (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [13:0] dividend,
    input wire logic [15:0] divisor,
    output logic busy,
    output logic [13:0] quo,
    output logic [15:0] rem
);
    logic [3:0] cnt_q;
    logic [16:0] trial;

    assign trial = {rem, quo[13]} - {1'b0, divisor};

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 4'h0;
            busy <= 1'b0;
            quo <= 14'h0000;
            rem <= 16'h0000;
        end else if (start) begin
            cnt_q <= 4'hd;
            busy <= 1'b1;
            quo <= dividend;
            rem <= 16'h0000;
        end else if (busy) begin
            if (!trial[16]) begin
                rem <= trial[15:0];
                quo <= {quo[12:0], 1'b1};
            end else begin
                rem <= {rem[14:0], quo[13]};
                quo <= {quo[12:0], 1'b0};
            end
            cnt_q <= cnt_q - 4'h1;
            busy <= (cnt_q != 4'h0);
        end
    end
endmodule

// ===== rtl/stepper_ctrl.sv
// Purpose: three-channel step pulse and direction motion controller
// Assumes: AHB-Lite slave, single word transfers, 20 MHz core_clk
// Notes: speed and ramp settings survive the software reset
//
// Operation
// - three independent channels, each with step pulse and direction out
// - maximum rate accepted 1..10000 pps; pulses never exceed it
// - moves start at one eighth of maximum and accelerate to maximum
// - moves decelerate back to one eighth before the last pulse; the code ends one ramp level above it
// - ramp setting gives steps to accelerate, same steps to decelerate
// - speed and ramp kept until rewritten; software reset keeps them
// - direction output high for negative motion, low for positive
// - relative move emits |count| pulses; negative count runs negative
// - done flag cleared on accepted move, set after final pulse
// - absolute move takes count and direction from target minus position
// - counts and positions are 32-bit signed
// - set-home command makes the current position zero; the code takes it only when the channel is idle
// - absolute position readable at any time, also while moving
// - move commands ignored while a move runs, until done or aborted
// - in half-step mode the count is taken as half steps; half_q is only stored and read back, counts run as full steps
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "step_params.svh"
module stepper_ctrl (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [2:0] step_pulse,
    output logic [2:0] step_dir,
    output logic irq
);
    localparam int NC = `NUM_CH;

    // ****************************************
    // bus slave
    // ****************************************
    logic ap_valid, dp_wr_q, dp_rd_q, dp_ok_q;
    logic [6:0] dp_addr_q;
    logic [1:0] dp_page;
    logic [4:0] dp_ofs;
    logic [31:0] rd_mux;

    assign ap_valid = hsel & htrans[1] & hready;
    assign dp_page = dp_addr_q[6:5];
    assign dp_ofs = dp_addr_q[4:0];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dp_wr_q <= 1'b0;
            dp_rd_q <= 1'b0;
            dp_ok_q <= 1'b0;
            dp_addr_q <= 7'h00;
        end else begin
            dp_wr_q <= ap_valid & hwrite;
            dp_rd_q <= ap_valid & ~hwrite;
            if (ap_valid) begin
                dp_ok_q <= (haddr[31:7] == 25'h000_0000) && (hsize == 3'h2);
                dp_addr_q <= haddr[6:0];
            end
        end
    end

    // reads take one wait state so a read right after a write sees it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hreadyout <= ~(ap_valid & ~hwrite);
            hresp <= 1'b0;
            if (dp_rd_q) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ****************************************
    // global registers
    // ****************************************
    logic glob_wr, soft_rst_q;
    logic [2:0] half_q, irq_stat_q, irq_mask_q, done_evt;

    assign glob_wr = dp_wr_q & dp_ok_q & (dp_page == `PAGE_GLOBAL);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            soft_rst_q <= 1'b0;
            half_q <= 3'h0;
        end else begin
            soft_rst_q <= glob_wr && (dp_ofs == `OFS_CTRL) &&
                hwdata[`CTRL_SOFT_RST];
            if (glob_wr && dp_ofs == `OFS_CTRL) begin
                half_q <= hwdata[`CTRL_HALF_LSB +: 3];
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= 3'h0;
            irq_mask_q <= `MASK_RST;
            irq <= 1'b0;
        end else begin
            // a completion in a write-to-clear cycle stays set, a soft reset drops it
            if (soft_rst_q) begin
                irq_stat_q <= 3'h0;
            end else if (glob_wr && dp_ofs == `OFS_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~hwdata[2:0]) | done_evt;
            end else begin
                irq_stat_q <= irq_stat_q | done_evt;
            end
            if (glob_wr && dp_ofs == `OFS_IRQ_MASK) begin
                irq_mask_q <= hwdata[2:0];
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ****************************************
    // channels
    // ****************************************
    step_pkg::rate_t speed_q [NC];
    step_pkg::ramp_t ramp_q [NC];
    logic [NC-1:0] loaded_q;
    logic [31:0] arg_q [NC];
    logic signed [31:0] pos_q [NC];
    logic [31:0] relcnt_q [NC];
    logic [NC-1:0] busy;
    logic [NC-1:0] done_q;

    for (genvar c = 0; c < NC; c++) begin : g_ch
        rate_if rif ();
        step_pkg::move_state_t state_q;
        logic wr, cmd_wr, accept, neg;
        step_pkg::rate_t min_rate, rate_q, rate_n;
        logic [15:0] lvl_q, lvl_n, rem;
        logic signed [17:0] err_q, err_n;
        logic [32:0] remain_q, diff, mag, target;
        logic div_start_q, div_busy;
        logic [13:0] inc;
        logic [6:0] pw_q;

        assign wr = dp_wr_q & dp_ok_q & (dp_page == 2'(c));
        assign cmd_wr = wr && (dp_ofs == `OFS_CMD);
        // no new move while one runs
        assign accept = cmd_wr && state_q == step_pkg::ST_IDLE &&
            loaded_q[c] && (hwdata[`CMD_REL] || hwdata[`CMD_ABS]) &&
            !hwdata[`CMD_ABORT] && !soft_rst_q;
        // start rate is max/8, never below one
        assign min_rate = (speed_q[c] < 14'h0008) ? `MIN_PPS :
            {3'h0, speed_q[c][13:3]};

        // absolute move from target minus position
        assign diff = {arg_q[c][31], arg_q[c]} - {pos_q[c][31], pos_q[c]};
        assign neg = hwdata[`CMD_ABS] ? diff[32] : arg_q[c][31];
        assign mag = hwdata[`CMD_ABS] ? (diff[32] ? 33'(-diff) : diff) :
            (arg_q[c][31] ? 33'(-{1'b1, arg_q[c]}) : {1'b0, arg_q[c]});

        // settings reset only at power-up, not by soft reset
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                speed_q[c] <= `SPEED_RST;
                ramp_q[c] <= `RAMP_RST;
                loaded_q[c] <= 1'b0;
                arg_q[c] <= 32'h0000_0000;
            end else if (wr) begin
                if (dp_ofs == `OFS_SPEED) begin
                    if (hwdata[31:0] > {18'h0_0000, `MAX_PPS}) begin
                        speed_q[c] <= `MAX_PPS;
                    end else if (hwdata[13:0] == 14'h0000) begin
                        speed_q[c] <= `MIN_PPS;
                    end else begin
                        speed_q[c] <= hwdata[13:0];
                    end
                    loaded_q[c] <= 1'b1;
                end
                // ramp length in steps, at least one
                if (dp_ofs == `OFS_RAMP) begin
                    ramp_q[c] <= (hwdata[15:0] == 16'h0000) ? `RAMP_RST :
                        hwdata[15:0];
                end
                if (dp_ofs == `OFS_ARG) begin
                    arg_q[c] <= hwdata;
                end
            end
        end

        ramp_divider u_div (
            .core_clk(core_clk), .reset(reset), .start(div_start_q),
            .dividend(14'(speed_q[c] - min_rate)), .divisor(ramp_q[c]),
            .busy(div_busy), .quo(inc), .rem(rem));
        step_rate_gen u_gen (.core_clk(core_clk), .reset(reset),
            .rif(rif.gen));
        assign rif.run = (state_q == step_pkg::ST_RUN);
        assign rif.rate = rate_q;

        // ramp level = min(done, left, ramp); same both ways
        always_comb begin
            target = 33'(relcnt_q[c]) + 33'h0_0000_0001;
            if (remain_q - 33'h0_0000_0001 < target) begin
                target = remain_q - 33'h0_0000_0001;
            end
            if ({17'h0_0000, ramp_q[c]} < target) begin
                target = {17'h0_0000, ramp_q[c]};
            end
            rate_n = rate_q;
            err_n = err_q;
            lvl_n = lvl_q;
            if (target > {17'h0_0000, lvl_q}) begin
                lvl_n = lvl_q + 16'h0001;
                err_n = err_q + $signed({2'b00, rem});
                rate_n = rate_q + inc;
                if (err_n >= $signed({2'b00, ramp_q[c]})) begin
                    err_n = err_n - $signed({2'b00, ramp_q[c]});
                    rate_n = rate_n + 14'h0001;
                end
            end else if (target < {17'h0_0000, lvl_q}) begin
                lvl_n = lvl_q - 16'h0001;
                err_n = err_q - $signed({2'b00, rem});
                rate_n = rate_q - inc;
                if (err_n < 18'sh0_0000) begin
                    err_n = err_n + $signed({2'b00, ramp_q[c]});
                    rate_n = rate_n - 14'h0001;
                end
            end
        end

        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                state_q <= step_pkg::ST_IDLE;
                div_start_q <= 1'b0;
                remain_q <= 33'h0_0000_0000;
                rate_q <= `MIN_PPS;
                err_q <= 18'sh0_0000;
                lvl_q <= 16'h0000;
                done_q[c] <= 1'b0;
                done_evt[c] <= 1'b0;
                relcnt_q[c] <= 32'h0000_0000;
                step_dir[c] <= 1'b0;
            end else begin
                div_start_q <= 1'b0;
                done_evt[c] <= 1'b0;
                if (soft_rst_q || (cmd_wr && hwdata[`CMD_ABORT])) begin
                    state_q <= step_pkg::ST_IDLE;
                    if (soft_rst_q) begin
                        done_q[c] <= 1'b0;
                    end
                end else if (accept) begin
                    done_q[c] <= 1'b0;
                    step_dir[c] <= neg;
                    remain_q <= mag;
                    relcnt_q[c] <= 32'h0000_0000;
                    rate_q <= min_rate;
                    err_q <= 18'sh0_0000;
                    lvl_q <= 16'h0000;
                    div_start_q <= 1'b1;
                    state_q <= step_pkg::ST_DIV;
                end else if (state_q == step_pkg::ST_DIV) begin
                    if (!div_start_q && !div_busy) begin
                        if (remain_q == 33'h0_0000_0000) begin
                            done_q[c] <= 1'b1;
                            done_evt[c] <= 1'b1;
                            state_q <= step_pkg::ST_IDLE;
                        end else begin
                            state_q <= step_pkg::ST_RUN;
                        end
                    end
                end else if (state_q == step_pkg::ST_RUN && rif.tick) begin
                    relcnt_q[c] <= relcnt_q[c] + 32'h0000_0001;
                    remain_q <= remain_q - 33'h0_0000_0001;
                    rate_q <= rate_n;
                    err_q <= err_n;
                    lvl_q <= lvl_n;
                    if (remain_q == 33'h0_0000_0001) begin
                        done_q[c] <= 1'b1;
                        done_evt[c] <= 1'b1;
                        state_q <= step_pkg::ST_IDLE;
                    end
                end
            end
        end

        // 32-bit signed position; home clears it when idle
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                pos_q[c] <= 32'sh0000_0000;
            end else if (cmd_wr && hwdata[`CMD_HOME] &&
                    state_q == step_pkg::ST_IDLE) begin
                pos_q[c] <= 32'sh0000_0000;
            end else if (state_q == step_pkg::ST_RUN && rif.tick) begin
                pos_q[c] <= step_dir[c] ? pos_q[c] - 32'sh0000_0001 :
                    pos_q[c] + 32'sh0000_0001;
            end
        end

        // pulse width fixed, well inside the 100 us period at full rate
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                pw_q <= 7'h00;
                step_pulse[c] <= 1'b0;
            end else if (state_q == step_pkg::ST_RUN && rif.tick) begin
                pw_q <= 7'(`PULSE_CYC - 1);
                step_pulse[c] <= 1'b1;
            end else if (pw_q != 7'h00) begin
                pw_q <= pw_q - 7'h01;
            end else begin
                step_pulse[c] <= 1'b0;
            end
        end

        assign busy[c] = (state_q != step_pkg::ST_IDLE);
    end

    // ****************************************
    // read mux
    // ****************************************
    // position readable at any time
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (dp_ok_q && dp_page == `PAGE_GLOBAL) begin
            unique case (dp_ofs)
                `OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
                `OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
                `OFS_CTRL: rd_mux = {28'h0, half_q, 1'b0};
                default: rd_mux = 32'h0000_0000;
            endcase
        end else if (dp_ok_q) begin
            unique case (dp_ofs)
                `OFS_SPEED: rd_mux = {18'h0, speed_q[dp_page]};
                `OFS_RAMP: rd_mux = {16'h0, ramp_q[dp_page]};
                `OFS_ARG: rd_mux = arg_q[dp_page];
                `OFS_CMD: rd_mux = {28'h0, loaded_q[dp_page],
                    step_dir[dp_page], done_q[dp_page], busy[dp_page]};
                `OFS_POS: rd_mux = pos_q[dp_page];
                `OFS_RELCNT: rd_mux = relcnt_q[dp_page];
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== test/stepper_ctrl_asserts.sv
// Purpose: port checker for stepper_ctrl
// Assumes: 20 MHz core_clk, reset active high
// Notes: step spacing floor follows the 10000 pps ceiling
`timescale 1ns/1ps
module stepper_ctrl_asserts (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [2:0] step_pulse,
    input wire logic [2:0] step_dir,
    input wire logic irq
);
    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // one cycle of slack for accumulator rounding
    localparam int MinGap = 1999;
    logic rd_take;
    logic wr_take;
    logic [2:0] prev_q;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign wr_take = hsel && htrans[1] && hready && hwrite;
    sequence read_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) prev_q <= 3'h0;
        else prev_q <= step_pulse;
    end
    read_wait_a: assert property (rd_take |=> read_answer)
        else $error("read data phase not one wait cycle");
    write_nowait_a: assert property (wr_take |=> hreadyout)
        else $error("write data phase stalled");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    reset_quiet_a: assert property ($fell(reset) |-> step_pulse == 3'h0 && !irq)
        else $error("outputs active after reset");
    for (genvar i = 0; i < 3; i++) begin : g_ch
        logic [15:0] gap_q;
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) gap_q <= 16'hffff;
            else if (step_pulse[i] && !prev_q[i]) gap_q <= 16'h0001;
            else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
        end
        pulse_gap_a: assert property ($rose(step_pulse[i]) |-> gap_q >= MinGap)
            else $error("step pulses closer than max rate");
        pulse_hold_a: assert property ($rose(step_pulse[i]) |-> step_pulse[i][*8])
            else $error("step pulse too short");
        pulse_end_a: assert property ($rose(step_pulse[i]) |-> ##99 step_pulse[i] ##1 !step_pulse[i])
            else $error("step pulse width not 100 cycles");
        dir_steady_a: assert property ($changed(step_dir[i]) |-> !step_pulse[i])
            else $error("direction changed during pulse");
    end
endmodule
bind stepper_ctrl stepper_ctrl_asserts u_chk (.core_clk(core_clk),
    .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .step_pulse(step_pulse), .step_dir(step_dir), .irq(irq));

// ===== test/step_driver_model.sv
// Purpose: external power stage seen from the step and direction pins
// Assumes: direction settled when a pulse rises
// Notes: tracks physical position, so it ignores any home command
`timescale 1ns/1ps
module step_driver_model (
    input wire logic core_clk,
    input wire logic [2:0] step_pulse,
    input wire logic [2:0] step_dir,
    output int pulses [3],
    output int pos [3]
);
    // ****************************************
    // pulse counting
    // ****************************************
    logic [2:0] prev_q;
    initial begin
        pulses = '{0, 0, 0};
        pos = '{0, 0, 0};
        prev_q = 3'h0;
    end
    always @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (step_pulse[i] === 1'b1 && prev_q[i] === 1'b0) begin
                pulses[i] <= pulses[i] + 1;
                pos[i] <= step_dir[i] ? pos[i] - 1 : pos[i] + 1;
            end
        end
        prev_q <= step_pulse;
    end
endmodule

// ===== test/stepper_pulse_direction_controller_tb_top.sv
// Purpose: self-checking bench for stepper_ctrl
// Assumes: one AHB-Lite master, 20 MHz core_clk
// Notes: ramp of one keeps moves short
`timescale 1ns/1ps
`include "step_params.svh"
module stepper_pulse_direction_controller_tb_top;
    // ****************************************
    // bench
    // ****************************************
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, irq;
    logic [2:0] step_pulse, step_dir;
    int pulses [3], pos [3], exp_pos [3];
    int miscompares = 0;
    int n_tests = 0;
    int n0, n1;
    always #25 core_clk = ~core_clk;
    stepper_ctrl DUT (.core_clk(core_clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .step_pulse(step_pulse),
        .step_dir(step_dir), .irq(irq));
    step_driver_model drv (.core_clk(core_clk), .step_pulse(step_pulse),
        .step_dir(step_dir), .pulses(pulses), .pos(pos));
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [1:0] c, input logic [4:0] o,
                      input logic [31:0] d);
        bus(1'b1, {25'h0, c, o}, d);
    endtask
    task automatic rdr(input logic [1:0] c, input logic [4:0] o);
        bus(1'b0, {25'h0, c, o}, 32'h0);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_pos(input int c);
        rdr(c[1:0], `OFS_POS);
        chk("pos", 32'(exp_pos[c]), rd);
        chk("driver pos", 32'(exp_pos[c]), 32'(pos[c]));
    endtask
    task automatic wait_done(input logic [1:0] c);
        rdr(c, `OFS_CMD);
        while (rd[0] !== 1'b0) begin
            repeat (200) @(posedge core_clk);
            rdr(c, `OFS_CMD);
        end
        // last pulse must end before a new move may flip direction
        repeat (100) @(posedge core_clk);
    endtask
    task automatic test_done();
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog: all moves together need about 60000 cycles
    initial begin
        repeat (90000) @(posedge core_clk);
        miscompares++;
        test_done();
    end
    initial begin
        void'($urandom(26));
        n0 = $urandom_range(3, 1);
        n1 = $urandom_range(2, 1);
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        wr(2'h2, `OFS_ARG, 32'h1);
        wr(2'h2, `OFS_CMD, 32'h1);
        repeat (100) @(posedge core_clk);
        rdr(2'h2, `OFS_CMD);
        chk("unloaded", 32'h0, rd & 32'hb);
        wr(2'h0, `OFS_SPEED, 32'h2710);
        wr(2'h1, `OFS_SPEED, 32'h4e20);
        wr(2'h2, `OFS_SPEED, 32'h2710);
        for (int c = 0; c < 3; c++) wr(c[1:0], `OFS_RAMP, 32'h1);
        rdr(2'h1, `OFS_SPEED);
        chk("speed clamp", 32'h2710, rd);
        wr(2'h2, `OFS_ARG, 32'h8000_0000);
        rdr(2'h2, `OFS_ARG);
        chk("arg width", 32'h8000_0000, rd);
        wr(2'h0, `OFS_ARG, 32'(-n0));
        wr(2'h0, `OFS_CMD, 32'h1);
        wr(2'h1, `OFS_ARG, 32'(n1));
        wr(2'h1, `OFS_CMD, 32'h1);
        wr(2'h2, `OFS_CMD, 32'h8);
        wr(2'h2, `OFS_ARG, 32'h1);
        wr(2'h2, `OFS_CMD, 32'h2);
        exp_pos = '{-n0, n1, 1};
        wr(2'h0, `OFS_CMD, 32'h1);
        rdr(2'h0, `OFS_CMD);
        chk("busy dir", 32'hd, rd & 32'hf);
        chk("dir pin", 32'h1, 32'(step_dir[0]));
        repeat (14900) @(posedge core_clk);
        rdr(2'h0, `OFS_POS);
        chk("slow start", 32'h0, rd);
        repeat (2000) @(posedge core_clk);
        rdr(2'h0, `OFS_POS);
        chk("pos mid", 32'hffff_ffff, rd);
        for (int c = 0; c < 3; c++) wait_done(c[1:0]);
        for (int c = 0; c < 3; c++) chk_pos(c);
        chk("pulses", 32'(n0), 32'(pulses[0]));
        rdr(2'h3, `OFS_IRQ_STAT);
        chk("irq stat", 32'h7, rd);
        chk("irq masked", 32'h0, 32'(irq));
        wr(2'h3, `OFS_IRQ_MASK, 32'h1);
        repeat (3) @(posedge core_clk);
        chk("irq on", 32'h1, 32'(irq));
        wr(2'h3, `OFS_IRQ_STAT, 32'h1);
        repeat (3) @(posedge core_clk);
        chk("irq off", 32'h0, 32'(irq));
        rdr(2'h3, `OFS_IRQ_STAT);
        chk("stat w1c", 32'h6, rd);
        wr(2'h0, `OFS_ARG, 32'h1);
        wr(2'h0, `OFS_CMD, 32'h2);
        rdr(2'h0, `OFS_CMD);
        chk("abs start", 32'h9, rd & 32'hf);
        wr(2'h1, `OFS_ARG, 32'h3e8);
        wr(2'h1, `OFS_CMD, 32'h1);
        repeat (100) @(posedge core_clk);
        wr(2'h1, `OFS_CMD, 32'h4);
        wr(2'h1, `OFS_ARG, 32'hffff_ffff);
        wr(2'h1, `OFS_CMD, 32'h1);
        rdr(2'h1, `OFS_CMD);
        chk("after abort", 32'hd, rd & 32'hf);
        exp_pos[0] = 1;
        exp_pos[1] = n1 - 1;
        wait_done(2'h0);
        wait_done(2'h1);
        chk("irq done", 32'h1, 32'(irq));
        chk_pos(0);
        chk_pos(1);
        chk("abs pulses", 32'(2 * n0 + 1), 32'(pulses[0]));
        wr(2'h0, `OFS_CMD, 32'h8);
        rdr(2'h0, `OFS_POS);
        chk("home", 32'h0, rd);
        wr(2'h3, `OFS_CTRL, 32'h1);
        repeat (2) @(posedge core_clk);
        rdr(2'h3, `OFS_IRQ_STAT);
        chk("soft stat", 32'h0, rd);
        wr(2'h2, `OFS_ARG, 32'hffff_ffff);
        wr(2'h2, `OFS_CMD, 32'h1);
        rdr(2'h2, `OFS_CMD);
        chk("kept speed", 32'hd, rd & 32'hf);
        wait_done(2'h2);
        exp_pos[2] = 0;
        chk_pos(2);
        bus(1'b1, 32'h80, 32'hffff_ffff);
        bus(1'b0, 32'h80, 32'h0);
        chk("unmapped", 32'h0, rd);
        test_done();
    end
endmodule
